// *** hw/crp_pins_map.vh ***
// Register offsets, field positions, reset values and timing counts for the core pin block
`ifndef CRP_PINS_MAP_VH
`define CRP_PINS_MAP_VH

// ==========================================================
// Register byte offsets
`define CRP_OFS_CTRL 8'h00
`define CRP_OFS_STATUS 8'h04
`define CRP_OFS_LED 8'h08
`define CRP_OFS_CLKMON 8'h0C
`define CRP_OFS_RESET 8'h40

// ==========================================================
// Control register fields
`define CRP_CTRL_SOFT_RESET_EN 0
`define CRP_CTRL_EXT_TRISTATE 1
`define CRP_CTRL_RUN_FEATURE 2
`define CRP_CTRL_EXT_RUN_ERR 3
`define CRP_CTRL_LED_OVERRIDE 4
`define CRP_CTRL_WIDTH 5
`define CRP_CTRL_RESET 5'h00

// ==========================================================
// Status register fields
`define CRP_STAT_SIZE_SELECT 0
`define CRP_STAT_LINE_SENSE 1
`define CRP_STAT_LOAD_DONE 2
`define CRP_STAT_RESET_REQ 3
`define CRP_STAT_PHASE_OK 4

// ==========================================================
// LED register fields
`define CRP_LED_LINK_LSB 0
`define CRP_RUN_INDICATOR 4
`define CRP_ERROR_INDICATOR 5
`define CRP_LED_WIDTH 6
`define CRP_LED_RESET 6'h00

// ==========================================================
// Reset command bit
`define CRP_RESET_CMD_BIT 0

// ==========================================================
// Timing
`define CRP_CLK_PERIOD_NS 10
`define CRP_CORE_CLK_PERIOD_NS 40
`define CRP_CLK_RATIO (`CRP_CORE_CLK_PERIOD_NS / `CRP_CLK_PERIOD_NS)
`define CRP_CLKMON_WIDTH 8

`endif

// *** hw/crp_sync.v ***
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ns
module crp_sync #(
  parameter WIDTH = 1
) (
  clk,
  rst_b,
  asyncIn,
  syncOut
);
  input wire clk;
  input wire rst_b;
  input wire [WIDTH-1:0] asyncIn;
  output wire [WIDTH-1:0] syncOut;

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule

// *** hw/crp_eeprom_pins.v ***
// Serial EEPROM pin drivers for internal or external tristate operation
`timescale 1ns/1ns
module crp_eeprom_pins (
  clk,
  rst_b,
  externalMode,
  clockLowReq,
  lineLowReq,
  eepromSerialClockOut,
  eepromSerialClockOe,
  eepromSerialLineOut,
  eepromSerialLineOe,
  eepromLineDrive,
  eepromLineDriveEnable
);
  input wire clk;
  input wire rst_b;
  input wire externalMode;
  input wire clockLowReq;
  input wire lineLowReq;
  output reg eepromSerialClockOut;
  output reg eepromSerialClockOe;
  output wire eepromSerialLineOut;
  output reg eepromSerialLineOe;
  output wire eepromLineDrive;
  output reg eepromLineDriveEnable;

  // Data level is never driven high; a pull-up sets the released level
  assign eepromSerialLineOut = 1'b0;
  assign eepromLineDrive = 1'b0;

  // ==========================================================
  // Registered pin drive
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eepromSerialClockOut <= 1'b0;
      eepromSerialClockOe <= 1'b0;
      eepromSerialLineOe <= 1'b0;
      eepromLineDriveEnable <= 1'b0;
    end else if (externalMode) begin
      eepromSerialClockOut <= ~clockLowReq;
      eepromSerialClockOe <= 1'b1;
      eepromSerialLineOe <= 1'b0;
      eepromLineDriveEnable <= lineLowReq;
    end else begin
      eepromSerialClockOut <= 1'b0;
      eepromSerialClockOe <= clockLowReq;
      eepromSerialLineOe <= lineLowReq;
      eepromLineDriveEnable <= 1'b0;
    end
  end
endmodule

// *** hw/crp_core_pins.v ***
// Core reset, clock supervision, EEPROM pins and indicator outputs
// Functional notes
// - Low core reset returns every register to its reset value.
// - With soft reset enabled, a reset command raises the reset request output.
// - Reset request loops to the reset input; asserting reset clears the request.
// - Size select reads 0 up to 16 Kbit, 1 for 32 Kbit to 4 Mbit.
// - Internal tristate: EEPROM clock only drives low or releases.
// - External tristate: EEPROM clock is a plain 0/1 output.
// - External tristate: data out stays 0, enable controls driver, separate sense input.
// - Load done is 0 until EEPROM contents are loaded, then 1.
// - All indicator outputs are active high.
// - One link/activity indicator per configured port.
// - Run indicator shows status when enabled, stays 0 when disabled.
// - Run plus extended feature adds error and state-run outputs.
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "crp_pins_map.vh"
module crp_core_pins #(
  parameter PORTS = 3
) (
  clk,
  rst_b,
  avsAddress,
  avsRead,
  avsWrite,
  avsWritedata,
  avsReaddata,
  avsWaitrequest,
  fieldbusResetCmd,
  resetRequest,
  coreClock25m,
  eepromSizeSelect,
  eepromWideAddress,
  romClockLowReq,
  romLineLowReq,
  romLoadedIn,
  romLineLevel,
  eepromSerialClockOut,
  eepromSerialClockOe,
  eepromSerialLineIn,
  eepromSerialLineOut,
  eepromSerialLineOe,
  eepromLineSense,
  eepromLineDrive,
  eepromLineDriveEnable,
  eepromLoadDone,
  portActivity,
  runStatus,
  errorStatus,
  portLinkActivityLed,
  runIndicator,
  errorIndicator,
  stateLedRunPin
);
  input wire clk;
  input wire rst_b;
  input wire [7:0] avsAddress;
  input wire avsRead;
  input wire avsWrite;
  input wire [31:0] avsWritedata;
  output reg [31:0] avsReaddata;
  output wire avsWaitrequest;
  input wire fieldbusResetCmd;
  output reg resetRequest;
  input wire coreClock25m;
  input wire eepromSizeSelect;
  output reg eepromWideAddress;
  input wire romClockLowReq;
  input wire romLineLowReq;
  input wire romLoadedIn;
  output reg romLineLevel;
  output wire eepromSerialClockOut;
  output wire eepromSerialClockOe;
  input wire eepromSerialLineIn;
  output wire eepromSerialLineOut;
  output wire eepromSerialLineOe;
  input wire eepromLineSense;
  output wire eepromLineDrive;
  output wire eepromLineDriveEnable;
  output reg eepromLoadDone;
  input wire [2:0] portActivity;
  input wire runStatus;
  input wire errorStatus;
  output reg [2:0] portLinkActivityLed;
  output reg runIndicator;
  output reg errorIndicator;
  output reg stateLedRunPin;

  // Ports above PORTS stay dark even if their activity source toggles
  localparam [2:0] PORT_MASK = (PORTS >= 3) ? 3'h7 : ((PORTS == 2) ? 3'h3 : 3'h1);
  localparam integer CLK_RATIO_FULL = `CRP_CLK_RATIO;
  localparam [`CRP_CLKMON_WIDTH-1:0] CLK_RATIO = CLK_RATIO_FULL[`CRP_CLKMON_WIDTH-1:0];

  // ==========================================================
  // Input synchronisation
  wire [3:0] syncIn;
  wire sizeSync;
  wire lineSync;
  wire senseSync;
  wire coreClkSync;

  crp_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .asyncIn({coreClock25m, eepromLineSense, eepromSerialLineIn, eepromSizeSelect}),
    .syncOut(syncIn)
  );

  assign sizeSync = syncIn[0];
  assign lineSync = syncIn[1];
  assign senseSync = syncIn[2];
  assign coreClkSync = syncIn[3];

  // ==========================================================
  // Synchroniser fill
  // Stages reset to 0, which is not the idle level of the pulled-up line;
  // readings and edge detection wait until both stages carry pin samples
  reg [1:0] syncFill_reg;
  wire syncReady = (syncFill_reg == 2'h3);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncFill_reg <= 2'h0;
    end else if (!syncReady) begin
      syncFill_reg <= syncFill_reg + 2'h1;
    end
  end

  // ==========================================================
  // Registers
  reg [`CRP_CTRL_WIDTH-1:0] ctrl_reg;
  reg [`CRP_LED_WIDTH-1:0] led_reg;
  reg ack_reg;
  reg coreClkPrev_reg;
  reg [`CRP_CLKMON_WIDTH-1:0] clkCount_reg;
  reg [`CRP_CLKMON_WIDTH-1:0] clkPeriod_reg;
  reg phaseOk_reg;
  reg clkSeen_reg;

  wire softResetEn = ctrl_reg[`CRP_CTRL_SOFT_RESET_EN];
  wire externalMode = ctrl_reg[`CRP_CTRL_EXT_TRISTATE];
  wire runFeature = ctrl_reg[`CRP_CTRL_RUN_FEATURE];
  wire extRunErr = ctrl_reg[`CRP_CTRL_EXT_RUN_ERR];
  wire ledOverride = ctrl_reg[`CRP_CTRL_LED_OVERRIDE];

  // ==========================================================
  // Avalon-MM slave, one wait state per access
  // Ack lasts one cycle, so a held request sees exactly one wait state
  wire request = avsRead | avsWrite;
  wire writeTaken = avsWrite & ack_reg;
  wire ctrlWrite = writeTaken && (avsAddress == `CRP_OFS_CTRL);
  wire ledWrite = writeTaken && (avsAddress == `CRP_OFS_LED);
  wire hostResetCmd = writeTaken && (avsAddress == `CRP_OFS_RESET) && avsWritedata[`CRP_RESET_CMD_BIT];

  assign avsWaitrequest = request & ~ack_reg;

  reg [31:0] readdata_next;
  wire romLineSel = externalMode ? senseSync : lineSync;

  always @* begin
    readdata_next = 32'h00000000;
    case (avsAddress)
      `CRP_OFS_CTRL: begin
        readdata_next[`CRP_CTRL_WIDTH-1:0] = ctrl_reg;
      end
      `CRP_OFS_STATUS: begin
        readdata_next[`CRP_STAT_SIZE_SELECT] = eepromWideAddress;
        readdata_next[`CRP_STAT_LINE_SENSE] = romLineLevel;
        readdata_next[`CRP_STAT_LOAD_DONE] = eepromLoadDone;
        readdata_next[`CRP_STAT_RESET_REQ] = resetRequest;
        readdata_next[`CRP_STAT_PHASE_OK] = phaseOk_reg;
      end
      `CRP_OFS_LED: begin
        readdata_next[`CRP_LED_WIDTH-1:0] = led_reg;
      end
      `CRP_OFS_CLKMON: begin
        readdata_next[`CRP_CLKMON_WIDTH-1:0] = clkPeriod_reg;
      end
      default: begin
        readdata_next = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      avsReaddata <= 32'h00000000;
      ctrl_reg <= `CRP_CTRL_RESET;
      led_reg <= `CRP_LED_RESET;
    end else begin
      ack_reg <= request & ~ack_reg;
      // Captured on the wait cycle so the data already stand when waitrequest drops
      if (avsRead && !ack_reg) begin
        avsReaddata <= readdata_next;
      end
      if (ctrlWrite) begin
        ctrl_reg <= avsWritedata[`CRP_CTRL_WIDTH-1:0];
      end
      if (ledWrite) begin
        led_reg <= avsWritedata[`CRP_LED_WIDTH-1:0];
      end
    end
  end

  // ==========================================================
  // Self-reset request
  // Held until rst_b falls; the loop back through rst_b is what ends it
  // Fieldbus command is a same-clock pulse, so it needs no synchroniser
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resetRequest <= 1'b0;
    end else if (softResetEn && (hostResetCmd || fieldbusResetCmd)) begin
      resetRequest <= 1'b1;
    end
  end

  // ==========================================================
  // Core clock supervision: fast cycles per core clock period
  wire coreClkRise = syncReady & coreClkSync & ~coreClkPrev_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coreClkPrev_reg <= 1'b0;
      clkCount_reg <= {`CRP_CLKMON_WIDTH{1'b0}};
      clkPeriod_reg <= {`CRP_CLKMON_WIDTH{1'b0}};
      phaseOk_reg <= 1'b0;
      clkSeen_reg <= 1'b0;
    end else begin
      coreClkPrev_reg <= coreClkSync;
      if (coreClkRise) begin
        // First edge after reset only starts the count; its period would be partial
        clkSeen_reg <= 1'b1;
        if (clkSeen_reg) begin
          clkPeriod_reg <= clkCount_reg + 1'b1;
          phaseOk_reg <= (clkCount_reg + 1'b1) == CLK_RATIO;
        end
        clkCount_reg <= {`CRP_CLKMON_WIDTH{1'b0}};
      end else if (clkCount_reg != {`CRP_CLKMON_WIDTH{1'b1}}) begin
        // Saturates, so a period after a core clock stall cannot wrap to a plausible value; a stopped clock keeps the last period
        clkCount_reg <= clkCount_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // EEPROM size, line level and load flag
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      eepromWideAddress <= 1'b0;
      romLineLevel <= 1'b1;
      eepromLoadDone <= 1'b0;
    end else begin
      if (syncReady) begin
        eepromWideAddress <= sizeSync;
        romLineLevel <= romLineSel;
      end
      eepromLoadDone <= romLoadedIn;
    end
  end

  crp_eeprom_pins u_eeprom_pins (
    .clk(clk),
    .rst_b(rst_b),
    .externalMode(externalMode),
    .clockLowReq(romClockLowReq),
    .lineLowReq(romLineLowReq),
    .eepromSerialClockOut(eepromSerialClockOut),
    .eepromSerialClockOe(eepromSerialClockOe),
    .eepromSerialLineOut(eepromSerialLineOut),
    .eepromSerialLineOe(eepromSerialLineOe),
    .eepromLineDrive(eepromLineDrive),
    .eepromLineDriveEnable(eepromLineDriveEnable)
  );

  // ==========================================================
  // Indicators, logic 1 lights the LED
  wire [2:0] linkSrc = ledOverride ? led_reg[`CRP_LED_LINK_LSB+2:`CRP_LED_LINK_LSB] : portActivity;
  wire runSrc = ledOverride ? led_reg[`CRP_RUN_INDICATOR] : runStatus;
  wire errSrc = ledOverride ? led_reg[`CRP_ERROR_INDICATOR] : errorStatus;
  wire [2:0] linkLit = linkSrc & PORT_MASK;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      portLinkActivityLed <= 3'h0;
      runIndicator <= 1'b0;
      errorIndicator <= 1'b0;
      stateLedRunPin <= 1'b0;
    end else begin
      portLinkActivityLed <= linkLit;
      runIndicator <= runFeature & runSrc;
      errorIndicator <= runFeature & extRunErr & errSrc;
      stateLedRunPin <= runFeature & extRunErr & runSrc;
    end
  end
endmodule

// *** sim/crp_core_pins_chk.sv ***
// Port assertions for the core pin block
`timescale 1ns/1ns
module crp_core_pins_chk #(
  parameter PORTS = 3
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] avsAddress,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic avsWaitrequest,
  input wire logic fieldbusResetCmd,
  input wire logic resetRequest,
  input wire logic eepromSizeSelect,
  input wire logic eepromWideAddress,
  input wire logic romClockLowReq,
  input wire logic romLineLowReq,
  input wire logic romLoadedIn,
  input wire logic eepromSerialClockOut,
  input wire logic eepromSerialClockOe,
  input wire logic eepromSerialLineOut,
  input wire logic eepromSerialLineOe,
  input wire logic eepromLineDrive,
  input wire logic eepromLineDriveEnable,
  input wire logic eepromLoadDone,
  input wire logic [2:0] portLinkActivityLed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Cycles since reset release; keeps pin checks off the synchroniser fill
  logic [2:0] settle;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      settle <= 3'h0;
    end else if (settle != 3'h7) begin
      settle <= settle + 3'h1;
    end
  end
  // ==========
  // Reset loop and pins
  a_req_cause: assert property ($rose(resetRequest) |-> $past(fieldbusResetCmd) ||
    $past(avsWrite && !avsWaitrequest && avsAddress == 8'h40 && avsWritedata[0])) else $error("stray request");
  a_req_holds: assert property (resetRequest |=> resetRequest) else $error("request dropped");
  a_clock_high: assert property (eepromSerialClockOut |-> eepromSerialClockOe && $past(!romClockLowReq))
    else $error("clock driven high");
  a_line_zero: assert property (!eepromSerialLineOut && !eepromLineDrive) else $error("data out high");
  a_line_cause: assert property (eepromSerialLineOe || eepromLineDriveEnable |->
    $past(romLineLowReq) && !(eepromSerialLineOe && eepromLineDriveEnable)) else $error("stray line drive");
  a_load_set: assert property (settle != 3'h0 && romLoadedIn |=> eepromLoadDone) else $error("load done late");
  a_unused_leds: assert property ((portLinkActivityLed >> PORTS) == 3'h0) else $error("unused led lit");
  a_size_follow: assert property ((settle == 3'h7 && $stable(eepromSizeSelect)) [*4] |->
    eepromWideAddress == eepromSizeSelect) else $error("size not followed");
endmodule
bind crp_core_pins crp_core_pins_chk #(.PORTS(PORTS)) chk (.clk, .rst_b, .avsAddress, .avsWrite, .avsWritedata,
  .avsWaitrequest, .fieldbusResetCmd, .resetRequest, .eepromSizeSelect, .eepromWideAddress, .romClockLowReq,
  .romLineLowReq, .romLoadedIn, .eepromSerialClockOut, .eepromSerialClockOe, .eepromSerialLineOut,
  .eepromSerialLineOe, .eepromLineDrive, .eepromLineDriveEnable, .eepromLoadDone, .portLinkActivityLed);

// *** sim/crp_far_side.sv ***
// Far side: pulled-up EEPROM data line, slow core clock, reset loop
`timescale 1ns/1ns
module crp_far_side (
  input wire logic clk,
  input wire logic resetRequest,
  input wire logic lineOe,
  input wire logic lineOut,
  input wire logic driveEn,
  input wire logic drive,
  input wire logic pullLow,
  output logic lineLevel,
  output logic loopRst_b,
  output logic coreClock25m
);
  logic [2:0] holdCnt = 3'h0;
  // Pull-up wins unless some party drives low
  assign lineLevel = !((lineOe && !lineOut) || (driveEn && !drive) || pullLow);
  // Stretched so the core sees a clean multi-cycle reset
  assign loopRst_b = (holdCnt == 3'h0);
  always @(posedge clk) begin
    if (resetRequest) begin
      holdCnt <= 3'h4;
    end else if (holdCnt != 3'h0) begin
      holdCnt <= holdCnt - 3'h1;
    end
  end
  initial begin
    coreClock25m = 1'h0;
    // Free-running slow clock, 160 ns, toggling on falling edges of clk
    forever #80 coreClock25m = !coreClock25m;
  end
endmodule

// *** sim/test_crp_core_pins.sv ***
// Self-checking bench for the core pin block
`timescale 1ns/1ns
module test_crp_core_pins;
  logic clk, rst_b, loopRst_b, lineLevel, avsWaitrequest, resetRequest, coreClock25m, eepromWideAddress;
  logic romLineLevel, eepromSerialClockOut, eepromSerialClockOe, eepromSerialLineOut, eepromSerialLineOe;
  logic eepromLineDrive, eepromLineDriveEnable, eepromLoadDone, runIndicator, errorIndicator, stateLedRunPin;
  logic benchRst_b = 1'h0, avsRead = 1'h0, avsWrite = 1'h0, fieldbusResetCmd = 1'h0, eepromSizeSelect = 1'h0;
  logic romClockLowReq = 1'h0, romLineLowReq = 1'h0, romLoadedIn = 1'h0, runStatus = 1'h0, errorStatus = 1'h0;
  logic pullLow = 1'h0;
  logic [7:0] avsAddress = 8'h00;
  logic [31:0] avsWritedata = 32'h0, avsReaddata, rd;
  logic [2:0] portActivity = 3'h0, portLinkActivityLed;
  int fails = 0, n_checks = 0, cyc = 0;
  assign rst_b = benchRst_b && loopRst_b;
  crp_core_pins #(.PORTS(2)) dut (.clk, .rst_b, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsReaddata,
    .avsWaitrequest, .fieldbusResetCmd, .resetRequest, .coreClock25m, .eepromSizeSelect, .eepromWideAddress,
    .romClockLowReq, .romLineLowReq, .romLoadedIn, .romLineLevel, .eepromSerialClockOut, .eepromSerialClockOe,
    .eepromSerialLineIn(lineLevel), .eepromSerialLineOut, .eepromSerialLineOe, .eepromLineSense(lineLevel),
    .eepromLineDrive, .eepromLineDriveEnable, .eepromLoadDone, .portActivity, .runStatus, .errorStatus,
    .portLinkActivityLed, .runIndicator, .errorIndicator, .stateLedRunPin);
  crp_far_side far (.clk, .resetRequest, .lineOe(eepromSerialLineOe), .lineOut(eepromSerialLineOut),
    .driveEn(eepromLineDriveEnable), .drive(eepromLineDrive), .pullLow, .lineLevel, .loopRst_b, .coreClock25m);
  // ==========
  // Helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avsWrite <= wr;
    avsRead <= !wr;
    avsAddress <= a;
    avsWritedata <= d;
    do @(posedge clk); while (avsWaitrequest !== 1'h0);
    rd = avsReaddata;
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic req(input logic rq, input logic ck, input int n);
    romLineLowReq <= rq;
    romClockLowReq <= ck;
    wt(n);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chk("level", 32'h1, romLineLevel);
    rdchk("ctrl", 8'h00, 32'h0);
    rdchk("led", 8'h08, 32'h0);
    $display("test reset values done");
  endtask
  task automatic t_eeprom;
    req(1'h1, 1'h1, 2);
    chk("clkOut", 32'h0, eepromSerialClockOut);
    chk("lineOe", 32'h1, eepromSerialLineOe);
    wt(3);
    chk("level", 32'h0, romLineLevel);
    req(1'h0, 1'h0, 2);
    chk("clkOe", 32'h0, eepromSerialClockOe);
    chk("clkOut", 32'h0, eepromSerialClockOut);
    chk("lineOe", 32'h0, eepromSerialLineOe);
    bus(1'h1, 8'h00, 32'h2);
    wt(2);
    chk("clkOut", 32'h1, eepromSerialClockOut);
    req(1'h1, 1'h1, 5);
    chk("clkOut", 32'h0, eepromSerialClockOut);
    chk("driveEn", 32'h1, eepromLineDriveEnable);
    chk("level", 32'h0, romLineLevel);
    pullLow <= 1'h1;
    req(1'h0, 1'h0, 5);
    chk("level", 32'h0, romLineLevel);
    chk("lineOe", 32'h0, eepromSerialLineOe);
    bus(1'h1, 8'h00, 32'h0);
    pullLow <= 1'h0;
    eepromSizeSelect <= 1'h1;
    romLoadedIn <= 1'h1;
    wt(5);
    chk("wide", 32'h1, eepromWideAddress);
    chk("loaded", 32'h1, eepromLoadDone);
    rdchk("status", 8'h04, 32'h7);
    $display("test eeprom pins done");
  endtask
  task automatic t_leds;
    portActivity <= 3'h7;
    runStatus <= 1'h1;
    errorStatus <= 1'h1;
    wt(2);
    chk("links", 32'h3, portLinkActivityLed);
    chk("run", 32'h0, runIndicator);
    bus(1'h1, 8'h00, 32'h4);
    wt(3);
    chk("run", 32'h1, runIndicator);
    chk("stateRun", 32'h0, stateLedRunPin);
    chk("err", 32'h0, errorIndicator);
    bus(1'h1, 8'h00, 32'hC);
    wt(3);
    chk("err", 32'h1, errorIndicator);
    chk("stateRun", 32'h1, stateLedRunPin);
    bus(1'h1, 8'h08, 32'h25);
    bus(1'h1, 8'h00, 32'h1C);
    wt(2);
    chk("links", 32'h1, portLinkActivityLed);
    chk("run", 32'h0, runIndicator);
    chk("err", 32'h1, errorIndicator);
    chk("stateRun", 32'h0, stateLedRunPin);
    rdchk("led", 8'h08, 32'h25);
    $display("test indicators done");
  endtask
  task automatic t_soft;
    bus(1'h1, 8'h40, 32'h1);
    wt(2);
    chk("request", 32'h0, resetRequest);
    bus(1'h1, 8'h00, 32'h1);
    fieldbusResetCmd <= 1'h1;
    wt(1);
    fieldbusResetCmd <= 1'h0;
    wt(1);
    chk("request", 32'h1, resetRequest);
    wt(8);
    rdchk("ctrl", 8'h00, 32'h0);
    bus(1'h1, 8'h00, 32'h1);
    bus(1'h1, 8'h40, 32'h1);
    wt(1);
    chk("request", 32'h1, resetRequest);
    wt(2);
    chk("loaded", 32'h0, eepromLoadDone);
    wt(6);
    chk("request", 32'h0, resetRequest);
    chk("loaded", 32'h1, eepromLoadDone);
    rdchk("unmapped", 8'h20, 32'h0);
    wt(40);
    rdchk("period", 8'h0C, 32'h10);
    $display("test reset loop done");
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      conclude;
    end
  end
  initial begin
    wt(20);
    benchRst_b <= 1'h1;
    t_reset;
    t_eeprom;
    t_leds;
    t_soft;
    conclude;
  end
endmodule
